// >>> pkg/ffs_map.vh
// constants for the furnace fault supervisor
`ifndef FFS_MAP_VH
`define FFS_MAP_VH
`define FFS_CLK_NS        10
`define FFS_TICK_NS       1000000
`define FFS_TICK_CYCLES   (`FFS_TICK_NS / `FFS_CLK_NS)
`define FFS_CNT_W         22
`define FFS_VALVE_WIN_MS  180000
`define FFS_WELD_WAIT_MS  5000
`define FFS_WEAK_MS       5000
`define FFS_STRONG_MS     5000
`define FFS_LOWV_WAIT_MS  5000
`define FFS_TSTAT_MIN_MS  5000
`define FFS_TSTAT_MAX_MS  20000
`define FFS_SELFCHK_MS    300000
`define FFS_DEBOUNCE_MS   2000
`define FFS_FALSE_FLAME_MS 10000
`define FFS_AUTO_RESTART_MS 3600000
`define FFS_POSTPURGE_MS  15000
`define FFS_COOL_DELAY_MS 5000
`define FFS_EVENT_LIMIT   3'h5
`define FFS_FC_NONE       4'h0
`define FFS_FC_HW         4'h1
`define FFS_FC_OOS        4'h2
`define FFS_FC_LINE       4'h3
`define FFS_FC_WEAK       4'h4
`define FFS_FC_LOWV       4'h5
`define FFS_FC_FUSE       4'h6
`define FFS_FC_SEQ        4'h7
`endif

// >>> hdl/ffs_tick.v
// common time base tick generator
`timescale 1ns/1ps
module ffs_tick #(
   parameter PERIOD = 100000
) (
   input  wire clk_in,
   input  wire rst_n_in,
   output reg  tick_out
);
   reg [31:0] cnt_reg;
   always @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         cnt_reg  <= 32'h0000_0000;
         tick_out <= 1'b0;
      end
      else if (cnt_reg == PERIOD - 1)
      begin
         cnt_reg  <= 32'h0000_0000;
         tick_out <= 1'b1;
      end
      else
      begin
         cnt_reg  <= cnt_reg + 32'h0000_0001;
         tick_out <= 1'b0;
      end
   end
endmodule

// >>> hdl/ffs_hold.v
// counts ticks while a condition holds, saturating at a limit
`timescale 1ns/1ps
`include "ffs_map.vh"
module ffs_hold #(
   parameter W     = 22,
   parameter LIMIT = 1
) (
   input  wire         clk_in,
   input  wire         rst_n_in,
   input  wire         tick_in,
   input  wire         cond_in,
   output wire         done_out,
   output reg  [W-1:0] count_out
);
   localparam [W-1:0] LIM = LIMIT;
   always @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         count_out <= {W{1'b0}};
      else if (!cond_in)
         count_out <= {W{1'b0}};
      else if (tick_in && count_out < LIM)
         count_out <= count_out + {{(W-1){1'b0}}, 1'b1};
   end
   assign done_out = cond_in && (count_out >= LIM);
endmodule

// >>> hdl/ffs_top.v
// furnace fault supervisor: valve, flame, line, supply and lockout handling
`timescale 1ns/1ps
`include "ffs_map.vh"
module ffs_top #(
   parameter TICK_CYCLES     = `FFS_TICK_CYCLES,
   parameter DEBOUNCE_MS     = `FFS_DEBOUNCE_MS,
   parameter FALSE_FLAME_MS  = `FFS_FALSE_FLAME_MS,
   parameter AUTO_RESTART_MS = `FFS_AUTO_RESTART_MS,
   parameter POSTPURGE_MS    = `FFS_POSTPURGE_MS,
   parameter COOL_DELAY_MS   = `FFS_COOL_DELAY_MS,
   parameter VALVE_WIN_MS    = `FFS_VALVE_WIN_MS,
   parameter SELFCHK_MS      = `FFS_SELFCHK_MS,
   parameter HOLD5_MS        = `FFS_WELD_WAIT_MS,
   parameter TSTAT_MIN_MS    = `FFS_TSTAT_MIN_MS,
   parameter TSTAT_MAX_MS    = `FFS_TSTAT_MAX_MS,
   parameter WEAK_MS         = `FFS_WEAK_MS,
   parameter STRONG_MS       = `FFS_STRONG_MS
) (
   input  wire       clk_in,
   input  wire       rst_n_in,
   input  wire       valve_volt_in,
   input  wire       flame_in,
   input  wire       flame_weak_in,
   input  wire       pressure_closed_in,
   input  wire       polarity_rev_in,
   input  wire       ground_missing_in,
   input  wire       low_24v_in,
   input  wire       fuse_bad_in,
   input  wire       heat_req_in,
   input  wire       cool_req_in,
   input  wire       fan_req_in,
   input  wire       seq_idle_in,
   input  wire       seq_ignition_in,
   input  wire       seq_warmup_in,
   input  wire       seq_ps_fault_in,
   input  wire       seq_firing_in,
   input  wire       seq_flame_expected_in,
   input  wire       seq_soft_lock_req_in,
   input  wire       limit_open_in,
   input  wire       inducer_run_in,
   input  wire       valve_drive_in,
   output wire       heat_grant_out,
   output wire       cool_grant_out,
   output wire       fan_grant_out,
   output wire       seq_hold_out,
   output wire       warmup_skip_out,
   output wire       treat_no_flame_out,
   output wire       outputs_off_out,
   output wire       relays_off_out,
   output wire       igniter_off_out,
   output wire       inducer_force_on_out,
   output wire       inducer_force_off_out,
   output wire       circ_heat_out,
   output wire       circ_cool_out,
   output wire       postpurge_out,
   output wire       soft_lock_out,
   output wire       hard_lock_out,
   output wire       selfchk_lock_out,
   output wire       line_fault_out,
   output wire       weak_flame_out,
   output wire       alarm_out,
   output wire       manual_reset_alarm_out,
   output reg        history_store_out,
   output reg        micro_reset_out,
   output reg  [3:0] fault_code_out,
   output reg  [2:0] event_count_out
);
   localparam W = `FFS_CNT_W;
   localparam [12:0] S_NORMAL = 13'h0001;
   localparam [12:0] S_MISW   = 13'h0002;
   localparam [12:0] S_WELDW  = 13'h0004;
   localparam [12:0] S_WELDR  = 13'h0008;
   localparam [12:0] S_OOS    = 13'h0010;
   localparam [12:0] S_PURGE  = 13'h0020;
   localparam [12:0] S_SOFT   = 13'h0040;
   localparam [12:0] S_HARD   = 13'h0080;
   localparam [12:0] S_SELF   = 13'h0100;
   localparam [12:0] S_LOWV   = 13'h0200;
   localparam [12:0] S_LOWW   = 13'h0400;
   localparam [12:0] S_FUSE   = 13'h0800;
   localparam [12:0] S_INIT   = 13'h1000;

   // two-stage synchronisers for pin inputs
   reg  [10:0] meta_reg;
   reg  [10:0] sync_reg;
   wire [10:0] pins = {valve_volt_in, flame_in, flame_weak_in, pressure_closed_in,
                       polarity_rev_in, ground_missing_in, low_24v_in, fuse_bad_in,
                       heat_req_in, cool_req_in, fan_req_in};
   always @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         meta_reg <= 11'h000;
         sync_reg <= 11'h000;
      end
      else
      begin
         meta_reg <= pins;
         sync_reg <= meta_reg;
      end
   end
   wire valve_s = sync_reg[10];
   wire flame_s = sync_reg[9];
   wire weak_s  = sync_reg[8];
   wire press_s = sync_reg[7];
   wire pol_s   = sync_reg[6];
   wire gnd_s   = sync_reg[5];
   wire lowv_s  = sync_reg[4];
   wire fuse_s  = sync_reg[3];
   wire heat_s  = sync_reg[2];
   wire cool_s  = sync_reg[1];
   wire fan_s   = sync_reg[0];

   reg  [12:0] state_reg;
   reg  [12:0] state_next;
   reg         heat_d_reg;
   reg         fail_make_reg;
   reg         pol_fault_reg;
   reg         weak_reg;
   reg  [3:0]  code_next;
   reg  [2:0]  cnt_next;
   wire        tick;

   ffs_tick #(.PERIOD(TICK_CYCLES)) u_tick (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .tick_out (tick)
   );

   wire normal  = state_reg[0];
   wire lim_exp;
   wire monitor = seq_idle_in | seq_ignition_in | seq_ps_fault_in |
                  (limit_open_in & ~inducer_run_in & ~lim_exp);
   wire miswire_raw = monitor & normal & valve_s & ~press_s;
   wire weld_raw    = monitor & normal & valve_s & ~valve_drive_in &
                      (inducer_run_in | press_s);
   wire unexp_flame = normal & heat_s & flame_s & ~seq_flame_expected_in;
   wire pol_mon     = normal & (seq_idle_in | seq_ignition_in) & ~seq_warmup_in;
   wire mis_done, off_done, nomake_done, ff_done, pol_done, weak_done, strong_done;
   wire hold5_done, purge_done, cool_done, restart_done, self_done;
   wire [W-1:0] heat_off_cnt;

   ffs_hold #(.W(W), .LIMIT(VALVE_WIN_MS)) u_lim (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .tick_in(tick),
      .cond_in(limit_open_in), .done_out(lim_exp), .count_out());
   ffs_hold #(.W(W), .LIMIT(DEBOUNCE_MS)) u_mis (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .tick_in(tick),
      .cond_in(miswire_raw), .done_out(mis_done), .count_out());
   ffs_hold #(.W(W), .LIMIT(DEBOUNCE_MS)) u_off (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .tick_in(tick),
      .cond_in(~valve_s), .done_out(off_done), .count_out());
   ffs_hold #(.W(W), .LIMIT(DEBOUNCE_MS)) u_nomake (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .tick_in(tick),
      .cond_in(valve_drive_in & ~valve_s), .done_out(nomake_done), .count_out());
   ffs_hold #(.W(W), .LIMIT(FALSE_FLAME_MS)) u_ff (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .tick_in(tick),
      .cond_in(unexp_flame), .done_out(ff_done), .count_out());
   ffs_hold #(.W(W), .LIMIT(DEBOUNCE_MS)) u_pol (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .tick_in(tick),
      .cond_in(pol_s & (pol_mon | pol_fault_reg)), .done_out(pol_done), .count_out());
   ffs_hold #(.W(W), .LIMIT(WEAK_MS)) u_weak (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .tick_in(tick),
      .cond_in(seq_firing_in & flame_s & weak_s), .done_out(weak_done), .count_out());
   ffs_hold #(.W(W), .LIMIT(STRONG_MS)) u_strong (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .tick_in(tick),
      .cond_in(flame_s & ~weak_s), .done_out(strong_done), .count_out());
   ffs_hold #(.W(W), .LIMIT(HOLD5_MS)) u_hold5 (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .tick_in(tick),
      .cond_in(state_reg[2] | (state_reg[10] & ~lowv_s)), .done_out(hold5_done),
      .count_out());
   ffs_hold #(.W(W), .LIMIT(POSTPURGE_MS)) u_purge (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .tick_in(tick),
      .cond_in(state_reg[5]), .done_out(purge_done), .count_out());
   ffs_hold #(.W(W), .LIMIT(COOL_DELAY_MS)) u_cool (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .tick_in(tick),
      .cond_in(state_reg[1] & cool_s), .done_out(cool_done), .count_out());
   ffs_hold #(.W(W), .LIMIT(AUTO_RESTART_MS)) u_restart (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .tick_in(tick),
      .cond_in(state_reg[6]), .done_out(restart_done), .count_out());
   ffs_hold #(.W(W), .LIMIT(SELFCHK_MS)) u_self (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .tick_in(tick),
      .cond_in(state_reg[8] & ~gnd_s & ~pol_s), .done_out(self_done), .count_out());
   ffs_hold #(.W(W), .LIMIT(TSTAT_MAX_MS)) u_tstat (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .tick_in(tick),
      .cond_in(~heat_s), .done_out(), .count_out(heat_off_cnt));

   localparam [W-1:0] TMIN = TSTAT_MIN_MS;
   localparam [W-1:0] TMAX = TSTAT_MAX_MS;
   wire tstat_reset = heat_s & ~heat_d_reg & (heat_off_cnt > TMIN) &
                      (heat_off_cnt < TMAX);
   wire lock_to_hard = (event_count_out >= `FFS_EVENT_LIMIT);

   // fault state machine, supply faults take priority
   always @*
   begin
      state_next = state_reg;
      code_next  = fault_code_out;
      cnt_next   = event_count_out;
      if (lowv_s && !state_reg[9])
      begin
         state_next = S_LOWV;
         code_next  = `FFS_FC_LOWV;
      end
      else if (fuse_s && !state_reg[9] && !state_reg[10])
      begin
         state_next = S_FUSE;
         code_next  = `FFS_FC_FUSE;
      end
      else if (gnd_s && (normal || state_reg[6]))
      begin
         state_next = S_SELF;
         code_next  = `FFS_FC_LINE;
      end
      else
      begin
         case (state_reg)
            S_INIT:
               state_next = S_NORMAL;
            S_NORMAL:
            begin
               if (weld_raw)
               begin
                  state_next = S_WELDW;
                  code_next  = `FFS_FC_HW;
                  cnt_next   = (event_count_out == 3'h7) ? 3'h7 : event_count_out + 3'h1;
               end
               else if (mis_done)
               begin
                  state_next = S_MISW;
                  code_next  = `FFS_FC_HW;
                  cnt_next   = (event_count_out == 3'h7) ? 3'h7 : event_count_out + 3'h1;
               end
               else if (ff_done)
               begin
                  state_next = S_OOS;
                  code_next  = `FFS_FC_OOS;
               end
               else if (seq_soft_lock_req_in)
               begin
                  state_next = S_SOFT;
                  code_next  = fail_make_reg ? `FFS_FC_HW : `FFS_FC_SEQ;
               end
            end
            S_MISW:
               if (off_done)
                  state_next = lock_to_hard ? S_HARD : S_SOFT;
            S_WELDW:
               if (hold5_done)
               begin
                  if (flame_s || valve_s)
                     state_next = S_WELDR;
                  else
                     state_next = lock_to_hard ? S_HARD : S_SOFT;
               end
            S_WELDR:
               if (!flame_s && off_done)
                  state_next = lock_to_hard ? S_HARD : S_SOFT;
            S_OOS:
               if (!flame_s)
                  state_next = S_PURGE;
            S_PURGE:
               if (purge_done)
               begin
                  state_next = S_NORMAL;
                  code_next  = `FFS_FC_NONE;
               end
            S_SOFT:
               if (tstat_reset || (restart_done && !valve_s))
               begin
                  state_next = S_NORMAL;
                  code_next  = `FFS_FC_NONE;
               end
            S_HARD:
               state_next = S_HARD;
            S_SELF:
               if (self_done)
               begin
                  state_next = S_NORMAL;
                  code_next  = `FFS_FC_NONE;
               end
            S_LOWV:
               if (!lowv_s)
                  state_next = S_LOWW;
            S_LOWW:
               if (hold5_done)
               begin
                  state_next = S_NORMAL;
                  code_next  = `FFS_FC_NONE;
               end
            S_FUSE:
               if (!fuse_s)
               begin
                  state_next = S_INIT;
                  code_next  = `FFS_FC_NONE;
               end
            default:
               state_next = S_INIT;
         endcase
      end
   end

   always @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         state_reg         <= S_INIT;
         fault_code_out    <= `FFS_FC_NONE;
         event_count_out   <= 3'h0;
         heat_d_reg        <= 1'b0;
         fail_make_reg     <= 1'b0;
         pol_fault_reg     <= 1'b0;
         weak_reg          <= 1'b0;
         history_store_out <= 1'b0;
         micro_reset_out   <= 1'b0;
      end
      else
      begin
         state_reg         <= state_next;
         fault_code_out    <= code_next;
         event_count_out   <= cnt_next;
         heat_d_reg        <= heat_s;
         history_store_out <= (state_next == S_LOWV) && !state_reg[9];
         micro_reset_out   <= state_reg[11] && (state_next == S_INIT);
         if (nomake_done)
            fail_make_reg <= 1'b1;
         else if (!heat_s || state_reg[12])
            fail_make_reg <= 1'b0;
         if (pol_done)
            pol_fault_reg <= 1'b1;
         else if (!pol_s || state_reg[12])
            pol_fault_reg <= 1'b0;
         if (weak_done)
            weak_reg <= 1'b1;
         else if (strong_done || !heat_s || state_reg[12])
            weak_reg <= 1'b0;
      end
   end

   wire supply_off = state_reg[9] | state_reg[10];
   wire req_ignore = supply_off | state_reg[11] | state_reg[12];
   wire heat_block = state_reg[6] | state_reg[7] | state_reg[8] | pol_fault_reg |
                     state_reg[1] | state_reg[2] | state_reg[3];
   assign heat_grant_out = heat_s & ~req_ignore & ~heat_block;
   assign cool_grant_out = cool_s & ~req_ignore;
   assign fan_grant_out  = fan_s & ~req_ignore;
   assign seq_hold_out       = unexp_flame & ~seq_warmup_in;
   assign warmup_skip_out    = unexp_flame & seq_warmup_in;
   assign treat_no_flame_out = nomake_done;
   assign outputs_off_out    = state_reg[1] | state_reg[2] | state_reg[3];
   assign relays_off_out     = supply_off;
   assign igniter_off_out    = state_reg[4] | outputs_off_out;
   assign inducer_force_on_out  = state_reg[1] | state_reg[3] | state_reg[4];
   assign inducer_force_off_out = state_reg[2] | supply_off;
   assign circ_heat_out = (state_reg[1] & ~cool_done) | state_reg[3] | state_reg[4];
   assign circ_cool_out = state_reg[1] & cool_done;
   assign postpurge_out = state_reg[5];
   assign soft_lock_out    = state_reg[6];
   assign hard_lock_out    = state_reg[7];
   assign selfchk_lock_out = state_reg[8];
   assign line_fault_out   = pol_fault_reg | state_reg[8];
   assign weak_flame_out   = weak_reg;
   assign alarm_out = (fault_code_out != `FFS_FC_NONE) | pol_fault_reg | weak_reg;
   assign manual_reset_alarm_out = state_reg[7];
endmodule

// >>> verification/ffs_plant.sv
// behavioural valve, flame sensor and pressure switch facing the supervisor
`timescale 1ns/1ps
module ffs_plant (
   input  wire clk_in,
   input  wire drive_in,
   input  wire inducer_in,
   input  wire weld_in,
   input  wire miswire_in,
   input  wire fail_open_in,
   input  wire flame_force_in,
   output reg  valve_volt_out,
   output reg  flame_out,
   output reg  press_out
);
   initial {valve_volt_out, flame_out, press_out} = 3'h0;
   // valve voltage follows the relay unless welded, miswired or open
   always @(posedge clk_in)
   begin
      valve_volt_out <= (drive_in & ~fail_open_in) | weld_in | miswire_in;
      press_out      <= inducer_in & ~miswire_in;
      flame_out      <= flame_force_in;
   end
endmodule

// >>> verification/ffs_top_assertions.sv
// concurrent checks on the fault supervisor ports
`timescale 1ns/1ps
`include "ffs_map.vh"
module ffs_chk (
   input wire       clk_in, rst_n_in, low_24v_in, heat_req_in, flame_in,
   input wire       valve_volt_in, valve_drive_in, inducer_run_in, seq_idle_in,
   input wire       heat_grant_out, cool_grant_out, fan_grant_out, relays_off_out,
   input wire       seq_hold_out, warmup_skip_out, inducer_force_off_out,
   input wire       inducer_force_on_out, circ_heat_out, circ_cool_out, outputs_off_out,
   input wire       igniter_off_out, postpurge_out, soft_lock_out, hard_lock_out,
   input wire       selfchk_lock_out, line_fault_out, weak_flame_out, alarm_out,
   input wire       manual_reset_alarm_out, history_store_out, micro_reset_out,
   input wire [3:0] fault_code_out,
   input wire [2:0] event_count_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);
   a_lowv_relays: assert property (low_24v_in [*6] |-> relays_off_out
      && !heat_grant_out && !cool_grant_out && !fan_grant_out)
      else $error("relay or grant active on low supply");
   a_history_lowv: assert property (history_store_out |-> relays_off_out)
      else $error("history stored outside low supply");
   a_pulse_once: assert property ((history_store_out || micro_reset_out) |=>
      !history_store_out && !micro_reset_out)
      else $error("pulse longer than one cycle");
   a_hard_manual: assert property (hard_lock_out |-> manual_reset_alarm_out
      && !heat_grant_out && event_count_out >= 3'h5)
      else $error("hard lockout wrong");
   a_lock_noheat: assert property ((soft_lock_out || selfchk_lock_out
      || line_fault_out) |-> !heat_grant_out)
      else $error("heat granted in lockout");
   a_line_combined: assert property (selfchk_lock_out |-> line_fault_out)
      else $error("ground fault not on line fault");
   a_weld_inducer: assert property ($rose(valve_volt_in) && !valve_drive_in
      && inducer_run_in && seq_idle_in ##1 (valve_volt_in && !valve_drive_in) [*3]
      |-> ##[0:2] inducer_force_off_out && alarm_out)
      else $error("inducer kept on with welded valve");
   a_event_step: assert property ($rose(inducer_force_off_out) && !relays_off_out |->
      event_count_out == $past(event_count_out) + 3'h1)
      else $error("event count not stepped");
   a_misw_outputs: assert property (outputs_off_out && !inducer_force_off_out
      |-> inducer_force_on_out && alarm_out && (circ_heat_out || circ_cool_out))
      else $error("miswire outputs wrong");
   a_oos_safe: assert property ((fault_code_out == `FFS_FC_OOS && !postpurge_out)
      |-> igniter_off_out && inducer_force_on_out && circ_heat_out && alarm_out)
      else $error("flame fault outputs wrong");
   a_flame_idle: assert property ((flame_in && !heat_req_in) [*4] |->
      !seq_hold_out && !warmup_skip_out)
      else $error("flame acted on without heat");
   a_weak_clear: assert property (!heat_req_in [*4] |-> !weak_flame_out)
      else $error("weak flame kept without heat");
   c_soft: cover property ($rose(soft_lock_out));
   c_hard: cover property ($rose(hard_lock_out));
   c_oos: cover property (fault_code_out == `FFS_FC_OOS);
   c_weak: cover property ($rose(weak_flame_out));
endmodule
bind ffs_top ffs_chk u_chk (.clk_in, .rst_n_in, .low_24v_in, .heat_req_in, .flame_in,
   .valve_volt_in, .valve_drive_in, .inducer_run_in, .seq_idle_in, .heat_grant_out,
   .cool_grant_out, .fan_grant_out, .relays_off_out, .seq_hold_out, .warmup_skip_out,
   .inducer_force_off_out, .inducer_force_on_out, .circ_heat_out, .circ_cool_out,
   .outputs_off_out, .igniter_off_out, .postpurge_out, .soft_lock_out, .hard_lock_out,
   .selfchk_lock_out, .line_fault_out, .weak_flame_out, .alarm_out,
   .manual_reset_alarm_out, .history_store_out, .micro_reset_out, .fault_code_out,
   .event_count_out);

// >>> verification/ffs_top_tb.sv
// self-checking bench for the fault supervisor
`timescale 1ns/1ps
`include "ffs_map.vh"
`define CHK(nm, e, a) \
   n_tests = n_tests + 1; \
   if ((a) !== (e)) \
   begin \
      $display("mismatch %s exp %h got %h", nm, e, a); \
      fails = fails + 1; \
   end
module ffs_top_tb;
   reg        clk, rst_n, heat, cool, fan, pol, gnd, low, fuse, idle, warm, fexp, sreq;
   reg        ind, vdrv, weld, misw, fopen, flm, wk, fire, lim;
   integer    fails, n_tests, hn, mn, i;
   wire       vv, fl, pc, ie, hg, cg, fg, sh, ws, tn, oo, ro, io, ifn, ifo, ch, cc;
   wire       pp, sl, hl, sc, lf, al, ma, hs, mr, wf;
   wire [3:0] fc;
   wire [2:0] ec;
   assign ie = (ind & ~ifo) | ifn;
   ffs_top #(.TICK_CYCLES(10), .DEBOUNCE_MS(3), .FALSE_FLAME_MS(6), .AUTO_RESTART_MS(50),
      .POSTPURGE_MS(4), .COOL_DELAY_MS(3), .VALVE_WIN_MS(20), .SELFCHK_MS(8), .HOLD5_MS(5),
      .TSTAT_MIN_MS(5), .TSTAT_MAX_MS(20), .WEAK_MS(4), .STRONG_MS(4)) u_dut (
      .clk_in(clk), .rst_n_in(rst_n), .valve_volt_in(vv), .flame_in(fl),
      .flame_weak_in(wk), .pressure_closed_in(pc), .polarity_rev_in(pol),
      .ground_missing_in(gnd), .low_24v_in(low), .fuse_bad_in(fuse), .heat_req_in(heat),
      .cool_req_in(cool), .fan_req_in(fan), .seq_idle_in(idle), .seq_ignition_in(1'b0),
      .seq_warmup_in(warm), .seq_ps_fault_in(1'b0), .seq_firing_in(fire),
      .seq_flame_expected_in(fexp), .seq_soft_lock_req_in(sreq), .limit_open_in(lim),
      .inducer_run_in(ie), .valve_drive_in(vdrv), .heat_grant_out(hg), .cool_grant_out(cg),
      .fan_grant_out(fg), .seq_hold_out(sh), .warmup_skip_out(ws), .treat_no_flame_out(tn),
      .outputs_off_out(oo), .relays_off_out(ro), .igniter_off_out(io),
      .inducer_force_on_out(ifn), .inducer_force_off_out(ifo), .circ_heat_out(ch),
      .circ_cool_out(cc), .postpurge_out(pp), .soft_lock_out(sl), .hard_lock_out(hl),
      .selfchk_lock_out(sc), .line_fault_out(lf), .weak_flame_out(wf), .alarm_out(al),
      .manual_reset_alarm_out(ma), .history_store_out(hs), .micro_reset_out(mr),
      .fault_code_out(fc), .event_count_out(ec));
   ffs_plant u_plant (.clk_in(clk), .drive_in(vdrv), .inducer_in(ie), .weld_in(weld),
      .miswire_in(misw), .fail_open_in(fopen), .flame_force_in(flm), .valve_volt_out(vv),
      .flame_out(fl), .press_out(pc));
   task ms(input integer n);
      repeat (n * 10) @(posedge clk);
   endtask
   task reset_dut;
      begin
         rst_n <= 1'b0;
         repeat (2) @(posedge clk);
         rst_n <= 1'b1;
         repeat (3) @(posedge clk);
      end
   endtask
   task finish_test;
      begin
         if (fails == 0 && n_tests > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // counts the one-cycle pulses
   always @(posedge clk)
   begin
      if (hs === 1'b1)
         hn <= hn + 1;
      if (mr === 1'b1)
         mn <= mn + 1;
   end
   initial
   begin
      #200000;
      fails = fails + 1;
      finish_test;
   end
   initial
   begin
      {rst_n, heat, cool, fan, pol, gnd, low, fuse, idle, warm, fexp, sreq} = 12'h000;
      {ind, vdrv, weld, misw, fopen, flm, wk, fire, lim} = 9'h000;
      {fails, n_tests, hn, mn} = 128'h0;
      reset_dut;
      {heat, cool, fan, idle, pol} <= 5'h1f;
      ms(5);
      `CHK("line", 4'hb, {lf, hg, cg, fg})
      {pol, gnd} <= 2'h1;
      ms(5);
      `CHK("ground", 4'hd, {sc, lf, hg, cg})
      gnd <= 1'b0;
      ms(6);
      `CHK("selfchk", 1'b1, sc)
      ms(4);
      `CHK("selfchk_end", 2'h1, {sc, hg})
      {idle, flm} <= 2'h1;
      ms(1);
      `CHK("hold", 1'b1, sh)
      ms(2);
      flm <= 1'b0;
      ms(1);
      `CHK("resume", 5'h00, {sh, fc})
      {warm, flm} <= 2'h3;
      ms(1);
      `CHK("skip", 1'b1, ws)
      ms(8);
      `CHK("oos", 7'h72, {io, ifn, ch, fc})
      {warm, flm} <= 2'h0;
      ms(1);
      `CHK("purge", 1'b1, pp)
      ms(6);
      `CHK("purge_end", 5'h00, {pp, fc})
      {heat, flm, idle} <= 3'h3;
      ms(8);
      `CHK("ignored", 5'h00, {sh, fc})
      {heat, flm, idle} <= 3'h5;
      for (i = 0; i < 5; i = i + 1)
      begin
         if (i == 0)
         begin
            {ind, weld} <= 2'h3;
            ms(1);
            `CHK("weld", 4'h9, {ifo, ec})
            ms(6);
            `CHK("relight", 2'h3, {ifn, ch})
            {ind, weld} <= 2'h0;
         end
         else
         begin
            misw <= 1'b1;
            ms(5);
            `CHK("miswire", {2'h3, i[2:0] + 3'h1}, {oo, al, ec})
            ms(4);
            `CHK("cool", 1'b1, cc)
            misw <= 1'b0;
         end
         ms(5);
         `CHK("lock", (i < 4) ? 2'h2 : 2'h1, {sl, hl})
         if (i < 4)
         begin
            `CHK("soft", 2'h1, {hg, cg})
            heat <= 1'b0;
            ms(8);
            heat <= 1'b1;
            ms(1);
            `CHK("restart", 1'b0, sl)
         end
      end
      `CHK("hard", 4'hb, {ma, hg, cg, fg})
      ms(60);
      `CHK("held", 1'b1, hl)
      reset_dut;
      `CHK("power", 4'h0, {hl, ec})
      low <= 1'b1;
      ms(1);
      `CHK("lowv", 5'h11, {ro, hg, cg, fg, hn == 1})
      low <= 1'b0;
      ms(3);
      `CHK("wait", 1'b0, hg)
      ms(4);
      `CHK("back", 1'b1, hg)
      fuse <= 1'b1;
      ms(1);
      `CHK("fuse", 5'h06, {hg, fc})
      fuse <= 1'b0;
      ms(1);
      `CHK("micro", 2'h3, {mn == 1, hg})
      {idle, vdrv, fopen} <= 3'h3;
      ms(5);
      `CHK("nomake", 1'b1, tn)
      sreq <= 1'b1;
      ms(1);
      `CHK("soft_hw", 5'h11, {sl, fc})
      {sreq, vdrv, fopen} <= 3'h0;
      ms(30);
      `CHK("auto", 1'b1, sl)
      ms(25);
      `CHK("auto_end", 1'b0, sl)
      {fexp, fire, flm, wk} <= 4'hf;
      ms(5);
      `CHK("weak", 2'h3, {wf, al})
      wk <= 1'b0;
      ms(3);
      `CHK("weak_held", 1'b1, wf)
      ms(2);
      `CHK("strong", 1'b0, wf)
      {fexp, fire, flm, misw} <= 4'h1;
      ms(5);
      `CHK("unwatched", 4'h0, {oo, ec})
      lim <= 1'b1;
      ms(4);
      `CHK("window", 4'h9, {oo, ec})
      finish_test;
   end
endmodule
